//--- rtl/spc_pkg.sv
// Constants, register map and field layout of the serial port control block.
// How it works
// - In Wait the port keeps running; any enabled event wakes the processor.
// - In Halt the control and mode bits freeze and the master clock stops until woken.
// - A slave wakes the processor from Halt through its transfer-complete event.
// - A second byte before the done flag is cleared sets the overrun flag.
// - Halt wake-up needs the internal slave select low at Halt entry.
// - All three events share one request, gated by enable and CPU mask.
// - All events exit Wait; only transfer-complete exits Halt.
// - Interrupt enable requests on a set done, overrun or mode fault flag, not on write collision; clear inhibits every request.
// - Peripheral enable connects the pins; cleared by select low in master mode.
// - Master select turns clock pin to output; cleared by mode fault.
// - Clock idle level bit sets serial clock idle level in both modes.
// - Capture edge bit picks first or second clock edge; both ends match.
// - Divider bits set master clock rate and do nothing in slave mode.
// - Codes 100, 000, 001 divide the CPU clock by 4, 8, 16.
// - Codes 110, 010, 011 divide the CPU clock by 32, 64, 128.
// - Reset clears the upper four control bits.
// - Done flag sets on byte end; status read then data access clears it.
// - Reading the status register clears the overrun flag.
package spc_pkg;

  // ****************************************************************
  // Register map and fields
  // ****************************************************************
  localparam logic [7:0] ADDR_DATA = 8'h01;
  localparam logic [7:0] ADDR_CTRL = 8'h02;
  localparam logic [7:0] ADDR_STAT = 8'h03;

  localparam int CTRL_IRQ_EN  = 7;
  localparam int CTRL_PERIPH  = 6;
  localparam int CTRL_DIV_EN  = 5;
  localparam int CTRL_MASTER  = 4;
  localparam int CTRL_IDLE    = 3;
  localparam int CTRL_CAPTURE = 2;
  localparam int CTRL_RATE_HI = 1;
  localparam int CTRL_RATE_LO = 0;

  localparam int STAT_DONE = 7;
  localparam int STAT_WCOL = 6;
  localparam int STAT_OVR  = 5;
  localparam int STAT_MODE_FAULT_FLAG = 4;
  localparam int STAT_ODIS = 2;
  localparam int STAT_SSM  = 1;
  localparam int STAT_SSI  = 0;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] READ_NONE  = 8'h00;

  // ****************************************************************
  // Master clock dividers, indexed by {div_enable, rate_select}
  // ****************************************************************
  localparam int DIV_W = 7;
  localparam logic [2:0] CODE_DIV4   = 3'h4;
  localparam logic [2:0] CODE_DIV8   = 3'h0;
  localparam logic [2:0] CODE_DIV16  = 3'h1;
  localparam logic [2:0] CODE_DIV32  = 3'h6;
  localparam logic [2:0] CODE_DIV64  = 3'h2;
  localparam logic [2:0] CODE_DIV128 = 3'h3;
  localparam logic [DIV_W-1:0] HALF_DIV4   = 7'h02;
  localparam logic [DIV_W-1:0] HALF_DIV8   = 7'h04;
  localparam logic [DIV_W-1:0] HALF_DIV16  = 7'h08;
  localparam logic [DIV_W-1:0] HALF_DIV32  = 7'h10;
  localparam logic [DIV_W-1:0] HALF_DIV64  = 7'h20;
  localparam logic [DIV_W-1:0] HALF_DIV128 = 7'h40;

  // ****************************************************************
  // Power state, Gray coded along run, halt, recover
  // ****************************************************************
  typedef enum logic [1:0] {
    SPC_RUN     = 2'h0,
    SPC_HALT    = 2'h1,
    SPC_RECOVER = 2'h3
  } spc_pwr_t;

endpackage

//--- rtl/spc_div_if.sv
// Link between the control block and its master clock divider.
interface spc_div_if;
  logic                        run;
  logic [spc_pkg::DIV_W-1:0]   half_cnt;
  logic                        tick;
  modport ctrl (output run, output half_cnt, input tick);
  modport div  (input run, input half_cnt, output tick);
endinterface

//--- rtl/spc_divider.sv
// Master serial clock divider producing a half-period enable pulse.
module spc_divider #(
  parameter int CNT_W = spc_pkg::DIV_W
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // Divider control
  spc_div_if.div   div
);

  if (CNT_W != spc_pkg::DIV_W) begin : g_chk
    $error("spc_divider: CNT_W must equal the interface width");
  end

  logic [CNT_W-1:0] cnt_q;
  logic             tick_q;
  logic [CNT_W-1:0] gap_q;

  // The count restarts whenever run drops, so a fresh start gives a full half period.
  always_ff @(posedge clk_i) begin
    if (srst_i || !div.run) begin
      cnt_q  <= '0;
      tick_q <= 1'b0;
    end else if (cnt_q == div.half_cnt - CNT_W'(1)) begin
      cnt_q  <= '0;
      tick_q <= 1'b1;
    end else begin
      cnt_q  <= cnt_q + CNT_W'(1);
      tick_q <= 1'b0;
    end
  end

  assign div.tick = tick_q;

  always_ff @(posedge clk_i) begin
    if (srst_i || !div.run || cnt_q == div.half_cnt - CNT_W'(1)) begin
      gap_q <= CNT_W'(1);
    end else begin
      gap_q <= gap_q + CNT_W'(1);
    end
  end

  a_tick_spacing: assert property (@(posedge clk_i) disable iff (srst_i)
    tick_q && div.run ##1 (div.run && $stable(div.half_cnt))[*1] ##0 (tick_q && div.run)
      |-> 1'b0 || (div.half_cnt == CNT_W'(1)))
    else $error("divider ticks closer than its half period");

  a_tick_period: assert property (@(posedge clk_i) disable iff (srst_i)
    div.run && $stable(div.half_cnt) && cnt_q == div.half_cnt - CNT_W'(1) && gap_q > CNT_W'(1)
      |-> gap_q == div.half_cnt)
    else $error("divider half period differs from its selected count");

endmodule

//--- rtl/spc_ctrl.sv
// Serial port control, status, interrupt and low-power handling.
module spc_ctrl (
  // Clock and reset
  input  wire logic       CLOCK_I,
  input  wire logic       SRST_I,
  // Register port
  input  wire logic [7:0] REG_ADDR_I,
  input  wire logic [7:0] REG_WDATA_I,
  input  wire logic       REG_WR_I,
  input  wire logic       REG_RD_I,
  output logic      [7:0] REG_RDATA_O,
  // Processor power and interrupt
  input  wire logic       WAIT_I,
  input  wire logic       HALT_I,
  input  wire logic       CC_MASK_I,
  output logic            IRQ_O,
  output logic            WAKE_O,
  // Shift datapath
  input  wire logic       XFER_DONE_I,
  input  wire logic [7:0] RX_BYTE_I,
  input  wire logic       XFER_BUSY_I,
  output logic            TX_LOAD_O,
  output logic      [7:0] TX_BYTE_O,
  output logic            SCK_TICK_O,
  output logic            PERIPH_ENABLE_O,
  output logic            MASTER_SELECT_O,
  output logic            CLK_IDLE_LEVEL_O,
  output logic            CAPTURE_EDGE_SELECT_O,
  output logic            PORT_ACTIVE_O,
  output logic            HALT_RECOVER_O,
  // Pins
  input  wire logic       SS_N_I,
  output logic            SCK_OE_N_O,
  output logic            MOSI_OE_N_O,
  output logic            MISO_OE_N_O
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic             irq_en_q;
  logic             periph_q;
  logic             div_en_q;
  logic             master_q;
  logic             idle_q;
  logic             capture_q;
  logic [1:0]       rate_q;
  logic             xfer_done_q;
  logic             wcol_q;
  logic             ovr_q;
  logic             mode_fault_flag_q;
  logic             odis_q;
  logic             ssm_q;
  logic             ssi_q;
  logic             done_arm_q;
  logic             mode_fault_flag_arm_q;
  logic [7:0]       rx_buf_q;
  logic [7:0]       tx_byte_q;
  logic             tx_load_q;
  logic [7:0]       rdata_q;
  logic             wake_ok_q;
  spc_pkg::spc_pwr_t pwr_q;
  spc_pkg::spc_pwr_t pwr_d;
  logic             ss_int;
  logic             stat_rd;
  logic             data_acc;
  logic             ctrl_wr;
  logic             stat_wr;
  logic             data_wr;
  logic             done_evt;
  logic             done_clr;
  logic             fault;
  logic             any_flag;
  logic             halted;
  logic [7:0]       ctrl_word;
  logic [7:0]       stat_word;

  spc_div_if div_link ();

  assign halted   = HALT_I;
  assign ss_int   = ssm_q ? ssi_q : SS_N_I;
  assign stat_rd  = REG_RD_I && REG_ADDR_I == spc_pkg::ADDR_STAT;
  assign data_acc = (REG_RD_I || REG_WR_I) && REG_ADDR_I == spc_pkg::ADDR_DATA;
  assign ctrl_wr  = REG_WR_I && !halted && REG_ADDR_I == spc_pkg::ADDR_CTRL;
  assign stat_wr  = REG_WR_I && !halted && REG_ADDR_I == spc_pkg::ADDR_STAT;
  assign data_wr  = REG_WR_I && !halted && REG_ADDR_I == spc_pkg::ADDR_DATA;
  // A byte may complete in Halt only for a slave selected when Halt began.
  assign done_evt = XFER_DONE_I && (!halted || wake_ok_q);
  assign done_clr = done_arm_q && data_acc && !halted;
  assign fault    = master_q && !ss_int && !halted;
  assign any_flag = xfer_done_q || mode_fault_flag_q || ovr_q;

  // ****************************************************************
  // Control register
  // ****************************************************************
  // While a mode fault stands, enable and master may only be set by the write that clears it.
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      {irq_en_q, periph_q, div_en_q, master_q} <= spc_pkg::CTRL_RESET[7:4];
      {idle_q, capture_q, rate_q} <= spc_pkg::CTRL_RESET[3:0];
    end else if (fault) begin
      periph_q <= 1'b0;
      master_q <= 1'b0;
    end else if (ctrl_wr) begin
      irq_en_q  <= REG_WDATA_I[spc_pkg::CTRL_IRQ_EN];
      div_en_q  <= REG_WDATA_I[spc_pkg::CTRL_DIV_EN];
      idle_q    <= REG_WDATA_I[spc_pkg::CTRL_IDLE];
      capture_q <= REG_WDATA_I[spc_pkg::CTRL_CAPTURE];
      rate_q    <= REG_WDATA_I[spc_pkg::CTRL_RATE_HI:spc_pkg::CTRL_RATE_LO];
      if (!mode_fault_flag_q || mode_fault_flag_arm_q) begin
        periph_q <= REG_WDATA_I[spc_pkg::CTRL_PERIPH];
        master_q <= REG_WDATA_I[spc_pkg::CTRL_MASTER];
      end else begin
        periph_q <= 1'b0;
        master_q <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Status flags
  // ****************************************************************
  // Hardware sets win over software clears in the same cycle.
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      xfer_done_q <= 1'b0;
      done_arm_q  <= 1'b0;
    end else begin
      if (done_evt) begin
        xfer_done_q <= 1'b1;
      end else if (done_clr) begin
        xfer_done_q <= 1'b0;
      end
      if (done_evt || done_clr) begin
        done_arm_q <= 1'b0;
      end else if (stat_rd && xfer_done_q) begin
        done_arm_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      ovr_q <= 1'b0;
    end else if (done_evt && xfer_done_q && !done_clr) begin
      ovr_q <= 1'b1;
    end else if (stat_rd) begin
      ovr_q <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      mode_fault_flag_q     <= 1'b0;
      mode_fault_flag_arm_q <= 1'b0;
    end else if (fault) begin
      mode_fault_flag_q     <= 1'b1;
      mode_fault_flag_arm_q <= 1'b0;
    end else if (ctrl_wr && mode_fault_flag_arm_q) begin
      mode_fault_flag_q     <= 1'b0;
      mode_fault_flag_arm_q <= 1'b0;
    end else if (stat_rd && mode_fault_flag_q) begin
      mode_fault_flag_arm_q <= 1'b1;
    end
  end

  // A write during a transfer is dropped and flagged, never loaded.
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      wcol_q <= 1'b0;
    end else if (data_wr && XFER_BUSY_I) begin
      wcol_q <= 1'b1;
    end else if (done_arm_q && REG_RD_I && REG_ADDR_I == spc_pkg::ADDR_DATA) begin
      wcol_q <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      {odis_q, ssm_q, ssi_q} <= 3'h0;
    end else if (stat_wr) begin
      odis_q <= REG_WDATA_I[spc_pkg::STAT_ODIS];
      ssm_q  <= REG_WDATA_I[spc_pkg::STAT_SSM];
      ssi_q  <= REG_WDATA_I[spc_pkg::STAT_SSI];
    end
  end

  // ****************************************************************
  // Data buffers
  // ****************************************************************
  // Only the first byte after a clear is kept; later ones are lost to overrun.
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      rx_buf_q <= 8'h00;
    end else if (done_evt && (!xfer_done_q || done_clr)) begin
      rx_buf_q <= RX_BYTE_I;
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      tx_byte_q <= 8'h00;
      tx_load_q <= 1'b0;
    end else begin
      tx_load_q <= data_wr && !XFER_BUSY_I && (!xfer_done_q || done_arm_q);
      if (data_wr && !XFER_BUSY_I && (!xfer_done_q || done_arm_q)) begin
        tx_byte_q <= REG_WDATA_I;
      end
    end
  end

  // ****************************************************************
  // Register read port
  // ****************************************************************
  assign ctrl_word = {irq_en_q, periph_q, div_en_q, master_q, idle_q, capture_q, rate_q};
  assign stat_word = {xfer_done_q, wcol_q, ovr_q, mode_fault_flag_q, 1'b0, odis_q, ssm_q, ssi_q};

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I || !REG_RD_I) begin
      rdata_q <= spc_pkg::READ_NONE;
    end else if (REG_ADDR_I == spc_pkg::ADDR_DATA) begin
      rdata_q <= rx_buf_q;
    end else if (REG_ADDR_I == spc_pkg::ADDR_CTRL) begin
      rdata_q <= ctrl_word;
    end else if (REG_ADDR_I == spc_pkg::ADDR_STAT) begin
      rdata_q <= stat_word;
    end else begin
      rdata_q <= spc_pkg::READ_NONE;
    end
  end

  // ****************************************************************
  // Power state
  // ****************************************************************
  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      spc_pkg::SPC_RUN: begin
        if (halted) begin
          pwr_d = spc_pkg::SPC_HALT;
        end
      end
      spc_pkg::SPC_HALT: begin
        if (!halted) begin
          pwr_d = (wake_ok_q && !master_q) ? spc_pkg::SPC_RECOVER : spc_pkg::SPC_RUN;
        end
      end
      spc_pkg::SPC_RECOVER: begin
        if (master_q || done_evt) begin
          pwr_d = spc_pkg::SPC_RUN;
        end else if (halted) begin
          pwr_d = spc_pkg::SPC_HALT;
        end
      end
      default: begin
        pwr_d = spc_pkg::SPC_RUN;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      pwr_q <= spc_pkg::SPC_RUN;
    end else begin
      pwr_q <= pwr_d;
    end
  end

  // The select level is sampled once at Halt entry; later changes do not matter.
  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      wake_ok_q <= 1'b0;
    end else if (halted && pwr_q != spc_pkg::SPC_HALT) begin
      wake_ok_q <= !ss_int && !master_q && periph_q;
    end else if (!halted) begin
      // A stale grant from an earlier Halt must not wake the next one.
      wake_ok_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Master clock divider
  // ****************************************************************
  always_comb begin
    case ({div_en_q, rate_q})
      spc_pkg::CODE_DIV4:   div_link.half_cnt = spc_pkg::HALF_DIV4;
      spc_pkg::CODE_DIV16:  div_link.half_cnt = spc_pkg::HALF_DIV16;
      spc_pkg::CODE_DIV32:  div_link.half_cnt = spc_pkg::HALF_DIV32;
      spc_pkg::CODE_DIV64:  div_link.half_cnt = spc_pkg::HALF_DIV64;
      spc_pkg::CODE_DIV128: div_link.half_cnt = spc_pkg::HALF_DIV128;
      default:              div_link.half_cnt = spc_pkg::HALF_DIV8;
    endcase
  end

  assign div_link.run = periph_q && master_q && !halted;

  spc_divider #(
    .CNT_W (spc_pkg::DIV_W)
  ) u_div (
    .clk_i  (CLOCK_I),
    .srst_i (SRST_I),
    .div    (div_link.div)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign IRQ_O  = irq_en_q && any_flag && !CC_MASK_I;
  assign WAKE_O = irq_en_q && ((WAIT_I && any_flag)
                  || (halted && wake_ok_q && xfer_done_q));

  assign REG_RDATA_O           = rdata_q;
  assign TX_LOAD_O             = tx_load_q;
  assign TX_BYTE_O             = tx_byte_q;
  assign SCK_TICK_O            = div_link.tick;
  assign PERIPH_ENABLE_O       = periph_q;
  assign MASTER_SELECT_O       = master_q;
  assign CLK_IDLE_LEVEL_O      = idle_q;
  assign CAPTURE_EDGE_SELECT_O = capture_q;
  assign PORT_ACTIVE_O         = periph_q && !halted;
  assign HALT_RECOVER_O        = pwr_q == spc_pkg::SPC_RECOVER;
  assign SCK_OE_N_O            = !(periph_q && master_q);
  assign MOSI_OE_N_O           = !(periph_q && master_q && !odis_q);
  assign MISO_OE_N_O           = !(periph_q && !master_q && !odis_q && !ss_int);

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);

  a_irq_on_done: assert property (
    XFER_DONE_I && !HALT_I && irq_en_q && !ctrl_wr ##1 !CC_MASK_I |-> IRQ_O)
    else $error("done event with enable set raised no request");
  a_irq_holds: assert property (
    IRQ_O && !stat_rd && !data_acc && !REG_WR_I ##1 !CC_MASK_I |-> IRQ_O)
    else $error("request dropped while its flag stood");
  a_fault_drops: assert property (
    fault |=> !PERIPH_ENABLE_O && !MASTER_SELECT_O && mode_fault_flag_q && SCK_OE_N_O)
    else $error("mode fault left enable or master set");
  a_ovr_second: assert property (
    done_evt ##1 (done_evt && !done_clr) |=> ovr_q)
    else $error("second byte before clear gave no overrun");
  a_ovr_clear: assert property (
    stat_rd && !(done_evt && xfer_done_q) |=> !ovr_q)
    else $error("status read left overrun set");
  a_done_clear: assert property (
    stat_rd && xfer_done_q && !done_evt ##1 (data_acc && !done_evt && !HALT_I) |=> !xfer_done_q)
    else $error("status read then data access did not clear done");
  a_halt_freeze: assert property (
    HALT_I |=> $stable(ctrl_word) && !SCK_TICK_O)
    else $error("control changed or clock ran during Halt");
  a_halt_wake: assert property (
    HALT_I && done_evt && irq_en_q ##1 HALT_I |-> WAKE_O)
    else $error("slave byte in Halt did not wake");
  a_halt_err_only: assert property (
    HALT_I && !WAIT_I && !xfer_done_q |-> !WAKE_O)
    else $error("error flag woke from Halt");
  a_halt_unsel: assert property (
    $rose(HALT_I) && ss_int ##1 (HALT_I && !WAIT_I)[*2] |-> !WAKE_O)
    else $error("wake from Halt without select at entry");
  a_reset_ctrl: assert property (disable iff (1'b0)
    SRST_I |=> ctrl_word[7:4] == spc_pkg::CTRL_RESET[7:4])
    else $error("upper control bits not cleared by reset");

endmodule

//--- dv/spc_far_model.sv
// Far-side serial device as seen through the shift datapath of the port.
module spc_far_model (
  // Clock and request
  input  wire logic       clk_i,
  input  wire logic       go_i,
  input  wire logic [7:0] byte_i,
  input  wire logic [2:0] len_i,
  // Datapath result
  output logic            done_o,
  output logic      [7:0] rx_o,
  output logic            busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] cnt_q;
  logic [7:0] hold_q;
  initial begin
    {done_o, busy_o, cnt_q, hold_q} = '0;
    rx_o = 8'h5a;
  end
  // ********
  // Byte transfer
  // ********
  // Both ends share clock idle level and capture edge, so each byte lands whole.
  always @(posedge clk_i) begin
    done_o <= 1'b0;
    if (go_i) begin
      cnt_q  <= {1'b0, len_i} + 4'h1;
      hold_q <= byte_i;
      busy_o <= 1'b1;
      rx_o   <= ~rx_o;
    end else if (cnt_q == 4'h1) begin
      cnt_q  <= 4'h0;
      done_o <= 1'b1;
      busy_o <= 1'b0;
      rx_o   <= hold_q;
    end else begin
      cnt_q <= (cnt_q == 4'h0) ? 4'h0 : cnt_q - 4'h1;
      // Outside the done cycle the byte lines carry junk, so a late sample shows up.
      rx_o  <= ~rx_o;
    end
  end
endmodule

//--- dv/spc_ctrl_tb.sv
// Self-checking bench for the serial port control block.
module spc_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] DT = spc_pkg::ADDR_DATA;
  localparam logic [7:0] CT = spc_pkg::ADDR_CTRL;
  localparam logic [7:0] ST = spc_pkg::ADDR_STAT;
  localparam logic [2:0] CODES [6] = '{3'h4, 3'h0, 3'h1, 3'h6, 3'h2, 3'h3};
  logic       clk = 1'b0;
  logic       srst, wr, rd, wait_m, halt, cc_mask, ss_n, go, done, busy;
  logic       irq, wake, tick, pe, ms, idle, cap, act, sck_oe_n, txl, rec;
  logic [7:0] txb;
  logic       rd_d = 1'b0;
  logic [7:0] addr, wdata, bt, rx, rdata, v, b1, b2;
  logic [2:0] ln;
  logic [7:0] exp_q[$];
  int         err_count = 0;
  int         cmp_count = 0;
  int         n;

  spc_ctrl dut (
    .CLOCK_I(clk), .SRST_I(srst), .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_WR_I(wr),
    .REG_RD_I(rd), .REG_RDATA_O(rdata), .WAIT_I(wait_m), .HALT_I(halt), .CC_MASK_I(cc_mask),
    .IRQ_O(irq), .WAKE_O(wake), .XFER_DONE_I(done), .RX_BYTE_I(rx), .XFER_BUSY_I(busy),
    .TX_LOAD_O(txl), .TX_BYTE_O(txb), .SCK_TICK_O(tick), .PERIPH_ENABLE_O(pe), .MASTER_SELECT_O(ms),
    .CLK_IDLE_LEVEL_O(idle), .CAPTURE_EDGE_SELECT_O(cap), .PORT_ACTIVE_O(act), .HALT_RECOVER_O(rec),
    .SS_N_I(ss_n), .SCK_OE_N_O(sck_oe_n), .MOSI_OE_N_O(), .MISO_OE_N_O()
  );
  spc_far_model far (.clk_i(clk), .go_i(go), .byte_i(bt), .len_i(ln), .done_o(done), .rx_o(rx), .busy_o(busy));

  always #12.5 clk = ~clk;

  // ********
  // Tasks
  // ********
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic results();
    $display("comparisons %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    {addr, wdata, wr} <= {a, d, 1'b1};
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic get(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    {addr, rd} <= {a, 1'b1};
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask
  task automatic xfer(input logic [7:0] b);
    @(posedge clk);
    {bt, ln, go} <= {b, 3'($urandom_range(5)), 1'b1};
    @(posedge clk);
    go <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n == 50) err_count++;
  endtask
  // Distance in cycles between two master clock half-period ticks.
  task automatic period();
    n = 0;
    while (tick !== 1'b1 && n < 300) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (tick !== 1'b1 && n < 300);
  endtask

  // Read data stand only in the cycle after the strobe.
  always @(negedge clk) begin
    if (rd_d && exp_q.size() > 0) begin
      chk(rdata, exp_q.pop_front());
    end
    rd_d = rd;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    results();
  end

  // ********
  // Scenarios
  // ********
  initial begin
    srst = 1'b1;
    {wr, rd, wait_m, halt, cc_mask, go, addr, wdata, bt, ln} = '0;
    ss_n = 1'b1;
    void'($urandom(32'h094f));
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    get(CT, 8'h00);
    get(8'h00, 8'h00);
    repeat (4) begin
      v = 8'($urandom);
      put(CT, 8'h00);
      put(CT, v);
      @(negedge clk);
      chk({pe, ms, idle, cap}, {v[6], v[4], v[3], v[2]});
      chk(sck_oe_n, !(v[6] && v[4]));
      get(CT, v);
    end
    for (int i = 0; i < 6; i++) begin
      put(CT, 8'h00);
      put(CT, {2'b01, CODES[i][2], 3'b100, CODES[i][1:0]});
      period();
      chk(8'(n), 8'(2 << i));
    end
    put(CT, 8'h63);
    period();
    chk(8'(n / 100), 8'h03);
    put(CT, 8'hd0);
    ss_n <= 1'b0;
    repeat (3) @(posedge clk);
    ss_n <= 1'b1;
    @(negedge clk);
    chk({pe, ms, irq}, 3'b001);
    @(posedge clk);
    {cc_mask, wait_m} <= 2'b11;
    @(negedge clk);
    chk({irq, wake}, 2'b01);
    @(posedge clk);
    {cc_mask, wait_m} <= 2'b00;
    get(ST, 8'h10);
    put(CT, 8'h00);
    @(negedge clk);
    chk(irq, 1'b0);
    b1 = 8'($urandom);
    b2 = ~b1;
    put(CT, 8'hc0);
    xfer(b1);
    @(negedge clk);
    chk(irq, 1'b1);
    xfer(b2);
    get(ST, 8'ha0);
    get(ST, 8'h80);
    get(DT, b1);
    @(negedge clk);
    chk(irq, 1'b0);
    put(DT, b2);
    @(negedge clk);
    chk(txl, 1'b1);
    chk(txb, b2);
    put(CT, 8'h40);
    xfer(b2);
    @(negedge clk);
    chk(irq, 1'b0);
    get(ST, 8'h80);
    get(DT, b2);
    put(CT, 8'hc0);
    // The far master selects this slave before it goes to Halt.
    ss_n <= 1'b0;
    @(posedge clk);
    halt <= 1'b1;
    put(CT, 8'h00);
    xfer(b1);
    @(negedge clk);
    chk({wake, irq, act}, 3'b110);
    @(posedge clk);
    {halt, ss_n} <= 2'b01;
    get(CT, 8'hc0);
    @(negedge clk);
    chk(rec, 1'b1);
    get(ST, 8'h80);
    get(DT, b1);
    // One more byte brings a slave back from its post-Halt state.
    xfer(b2);
    get(ST, 8'h80);
    get(DT, b2);
    @(negedge clk);
    chk(rec, 1'b0);
    halt <= 1'b1;
    xfer(b1);
    @(negedge clk);
    chk(wake, 1'b0);
    results();
  end
endmodule
